// >>> rtl/pmw_mapper.sv
// Purpose: paged memory window mapper with an AXI4-Lite register slave
// Assumes: cpu_addr, onchip_sel, rom_sel and gpio inputs are synchronous
// Notes: all mapped outputs appear one clock after the cpu address
//
// Added by the designer: the AXI4-Lite register port and the register addresses.

`timescale 1ns/10ps

module pmw_mapper (
  input wire logic sys_clk,                  // 25 MHz system clock
  input wire logic rst_b,                    // async reset, active low
  // axi4-lite slave
  input wire logic [pmw_pkg::PMW_ADDR_W-1:0] s_axi_awaddr, // write addr
  input wire logic s_axi_awvalid,            // write addr valid
  output logic s_axi_awready,                // write addr ready
  input wire logic [31:0] s_axi_wdata,       // write data
  input wire logic [3:0] s_axi_wstrb,        // byte strobes
  input wire logic s_axi_wvalid,             // write data valid
  output logic s_axi_wready,                 // write data ready
  output logic [1:0] s_axi_bresp,            // write response
  output logic s_axi_bvalid,                 // write response valid
  input wire logic s_axi_bready,             // write response ready
  input wire logic [pmw_pkg::PMW_ADDR_W-1:0] s_axi_araddr, // read addr
  input wire logic s_axi_arvalid,            // read addr valid
  output logic s_axi_arready,                // read addr ready
  output logic [31:0] s_axi_rdata,           // read data
  output logic [1:0] s_axi_rresp,            // read response
  output logic s_axi_rvalid,                 // read data valid
  input wire logic s_axi_rready,             // read data ready
  // cpu side
  input wire logic [15:0] cpu_addr,          // 64K cpu address
  input wire logic onchip_sel,               // regs, ram or eeprom hit
  input wire logic rom_sel,                  // enabled rom addressed
  // port logic side of the shared pins
  input wire logic [5:0] gpio_out,           // port data when pin is io
  input wire logic [5:0] gpio_oe_b,          // port enable, low drives
  output logic [5:0] gpio_in,                // pin level back to port
  // shared pins
  input wire logic [5:0] port_pin_in,        // pin level
  output logic [5:0] port_pin_out,           // pin drive value
  output logic [5:0] port_pin_oe_b,          // pin enable, low drives
  // mapped results
  output logic [18:0] exp_addr,              // expanded physical address
  output logic [18:0] gpcs_one_addr,         // chip select 1 decode addr
  output logic [18:0] gpcs_two_addr,         // chip select 2 decode addr
  output logic rom_respond,                  // internal rom answers
  output logic [1:0] win_hit                 // window two, one active
);
  import pmw_pkg::*;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] pin_assign_reg_r;
  logic [7:0] window_size_reg_r;
  logic [7:0] window_base_reg_r;
  logic [7:0] bank_select_one_r;
  logic [7:0] bank_select_two_r;

  logic [5:0] pin_assign_bits;
  logic [1:0] gpcs_addr_source;
  pmw_size_t win_one_size;
  pmw_size_t win_two_size;
  logic [2:0] win_one_base;
  logic [2:0] win_two_base;
  logic [5:0] win_one_bank;
  logic [5:0] win_two_bank;

  assign pin_assign_bits = pin_assign_reg_r[5:0];
  assign gpcs_addr_source = window_size_reg_r[PMW_GPCS_SRC_LSB +: 2];
  assign win_one_size =
    pmw_size_t'(window_size_reg_r[PMW_SIZE_ONE_LSB +: 2]);
  assign win_two_size =
    pmw_size_t'(window_size_reg_r[PMW_SIZE_TWO_LSB +: 2]);
  assign win_one_base = window_base_reg_r[PMW_BASE_ONE_LSB +: 3];
  assign win_two_base = window_base_reg_r[PMW_BASE_TWO_LSB +: 3];
  assign win_one_bank = bank_select_one_r[PMW_BANK_LSB +: 6];
  assign win_two_bank = bank_select_two_r[PMW_BANK_LSB +: 6];

  // ------------------------------------------------------------------
  // window decode
  // ------------------------------------------------------------------
  pmw_win_cfg_t cfg_one;
  pmw_win_cfg_t cfg_two;
  pmw_win_res_t res_one;
  pmw_win_res_t res_two;

  assign cfg_one = '{size: win_one_size, base: win_one_base,
                     bank: win_one_bank};
  assign cfg_two = '{size: win_two_size, base: win_two_base,
                     bank: win_two_bank};

  pmw_window u_win_one (
    .cfg(cfg_one),
    .cpu_addr(cpu_addr),
    .res(res_one)
  );

  pmw_window u_win_two (
    .cfg(cfg_two),
    .cpu_addr(cpu_addr),
    .res(res_two)
  );

  // ------------------------------------------------------------------
  // priority and address composition
  // ------------------------------------------------------------------
  logic hit_one;
  logic hit_two;
  logic [5:0] bank_addr_nxt;
  logic [18:0] exp_addr_nxt;
  logic rom_respond_nxt;

  // internal memories shadow the window, so no bank is applied there
  assign hit_one = res_one.hit & ~onchip_sel;
  assign hit_two = res_two.hit & ~res_one.hit & ~onchip_sel;

  always_comb begin
    bank_addr_nxt = {3'b000, cpu_addr[15:13]};
    if (hit_one) begin
      bank_addr_nxt = res_one.xa;
    end else if (hit_two) begin
      bank_addr_nxt = res_two.xa;
    end
  end

  assign exp_addr_nxt = {bank_addr_nxt, cpu_addr[12:0]};

  // rom shows up in bank zero only; elsewhere external memory answers
  assign rom_respond_nxt = rom_sel &
    (~(hit_one | hit_two) | (bank_addr_nxt[5:3] == 3'b000));

  // ------------------------------------------------------------------
  // mapped outputs
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_addr <= '0;
      rom_respond <= 1'b0;
      win_hit <= 2'b00;
    end else begin
      exp_addr <= exp_addr_nxt;
      rom_respond <= rom_respond_nxt;
      win_hit <= {hit_two, hit_one};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpcs_one_addr <= '0;
      gpcs_two_addr <= '0;
    end else begin
      gpcs_one_addr <= gpcs_addr_source[0] ? exp_addr_nxt
                                           : {3'b000, cpu_addr};
      gpcs_two_addr <= gpcs_addr_source[1] ? exp_addr_nxt
                                           : {3'b000, cpu_addr};
    end
  end

  // ------------------------------------------------------------------
  // shared pin multiplexer
  // ------------------------------------------------------------------
  // an address line is always driven; io pins follow the port logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_pin_out <= '0;
      port_pin_oe_b <= '1;
      gpio_in <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (pin_assign_bits[i]) begin
          port_pin_out[i] <= bank_addr_nxt[i];
          port_pin_oe_b[i] <= 1'b0;
        end else begin
          port_pin_out[i] <= gpio_out[i];
          port_pin_oe_b[i] <= gpio_oe_b[i];
        end
      end
      gpio_in <= port_pin_in;
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------------
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic aw_held_r;
  logic w_held_r;
  logic [PMW_ADDR_W-1:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic wr_strb_r;
  logic wr_go;

  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign b_hs = s_axi_bvalid & s_axi_bready;
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

  // address and data are taken in either order, one write at a time
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      aw_held_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (aw_hs) begin
      s_axi_awready <= 1'b0;
      aw_held_r <= 1'b1;
      wr_addr_r <= s_axi_awaddr;
    end else if (b_hs) begin
      s_axi_awready <= 1'b1;
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_wready <= 1'b1;
      w_held_r <= 1'b0;
      wr_data_r <= '0;
      wr_strb_r <= 1'b0;
    end else if (w_hs) begin
      s_axi_wready <= 1'b0;
      w_held_r <= 1'b1;
      wr_data_r <= s_axi_wdata[7:0];
      wr_strb_r <= s_axi_wstrb[0];
    end else if (b_hs) begin
      s_axi_wready <= 1'b1;
      w_held_r <= 1'b0;
    end
  end

  logic wr_known;
  always_comb begin
    wr_known = 1'b1;
    if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_PIN_ASSIGN[7:2]) begin
      wr_known = 1'b1;
    end else if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_WIN_SIZE[7:2]) begin
      wr_known = 1'b1;
    end else if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_WIN_BASE[7:2]) begin
      wr_known = 1'b1;
    end else if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_BANK_ONE[7:2]) begin
      wr_known = 1'b1;
    end else if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_BANK_TWO[7:2]) begin
      wr_known = 1'b1;
    end else if (wr_addr_r[PMW_ADDR_W-1:2] == PMW_OFF_STATUS[7:2]) begin
      wr_known = 1'b1; // read-only, write ignored
    end else begin
      wr_known = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PMW_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
    end else if (b_hs) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  logic wr_en;
  logic [PMW_ADDR_W-3:0] wr_idx;
  assign wr_en = wr_go & wr_strb_r;
  assign wr_idx = wr_addr_r[PMW_ADDR_W-1:2];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_assign_reg_r <= PMW_RST_PIN_ASSIGN;
      window_size_reg_r <= PMW_RST_WIN_SIZE;
      window_base_reg_r <= PMW_RST_WIN_BASE;
    end else if (wr_en) begin
      if (wr_idx == PMW_OFF_PIN_ASSIGN[7:2]) begin
        pin_assign_reg_r <= wr_data_r & PMW_MASK_PIN_ASSIGN;
      end else if (wr_idx == PMW_OFF_WIN_SIZE[7:2]) begin
        window_size_reg_r <= wr_data_r & PMW_MASK_WIN_SIZE;
      end else if (wr_idx == PMW_OFF_WIN_BASE[7:2]) begin
        window_base_reg_r <= wr_data_r & PMW_MASK_WIN_BASE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_select_one_r <= PMW_RST_BANK;
      bank_select_two_r <= PMW_RST_BANK;
    end else if (wr_en) begin
      if (wr_idx == PMW_OFF_BANK_ONE[7:2]) begin
        bank_select_one_r <= wr_data_r & PMW_MASK_BANK;
      end else if (wr_idx == PMW_OFF_BANK_TWO[7:2]) begin
        bank_select_two_r <= wr_data_r & PMW_MASK_BANK;
      end
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------------
  logic ar_hs;
  logic r_hs;
  logic [7:0] rd_byte;
  logic rd_known;
  logic [PMW_ADDR_W-3:0] rd_idx;

  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign r_hs = s_axi_rvalid & s_axi_rready;
  assign rd_idx = s_axi_araddr[PMW_ADDR_W-1:2];

  // unimplemented bits are already zero in the stored values
  always_comb begin
    rd_byte = 8'h00;
    rd_known = 1'b1;
    if (rd_idx == PMW_OFF_PIN_ASSIGN[7:2]) begin
      rd_byte = pin_assign_reg_r;
    end else if (rd_idx == PMW_OFF_WIN_SIZE[7:2]) begin
      rd_byte = window_size_reg_r;
    end else if (rd_idx == PMW_OFF_WIN_BASE[7:2]) begin
      rd_byte = window_base_reg_r;
    end else if (rd_idx == PMW_OFF_BANK_ONE[7:2]) begin
      rd_byte = bank_select_one_r;
    end else if (rd_idx == PMW_OFF_BANK_TWO[7:2]) begin
      rd_byte = bank_select_two_r;
    end else if (rd_idx == PMW_OFF_STATUS[7:2]) begin
      rd_byte = {5'b00000, rom_respond, win_hit};
    end else begin
      rd_known = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PMW_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_known ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pmw_mapper

// >>> rtl/pmw_pkg.sv
// Purpose: shared constants and types for the paged memory window mapper
// Assumes: 8-bit registers, each placed in the low byte of one AXI word
// Notes: size codes follow the two-bit window size field encoding

package pmw_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam int PMW_ADDR_W = 8;
  localparam logic [7:0] PMW_OFF_PIN_ASSIGN = 8'h00;
  localparam logic [7:0] PMW_OFF_WIN_SIZE = 8'h04;
  localparam logic [7:0] PMW_OFF_WIN_BASE = 8'h08;
  localparam logic [7:0] PMW_OFF_BANK_ONE = 8'h0c;
  localparam logic [7:0] PMW_OFF_BANK_TWO = 8'h10;
  localparam logic [7:0] PMW_OFF_STATUS = 8'h14;

  // ------------------------------------------------------------------
  // reset values and implemented-bit masks
  // ------------------------------------------------------------------
  localparam logic [7:0] PMW_RST_PIN_ASSIGN = 8'h00;
  localparam logic [7:0] PMW_RST_WIN_SIZE = 8'h00;
  localparam logic [7:0] PMW_RST_WIN_BASE = 8'h00;
  localparam logic [7:0] PMW_RST_BANK = 8'h00;
  localparam logic [7:0] PMW_MASK_PIN_ASSIGN = 8'h3f;
  localparam logic [7:0] PMW_MASK_WIN_SIZE = 8'hf3;
  localparam logic [7:0] PMW_MASK_WIN_BASE = 8'hee;
  localparam logic [7:0] PMW_MASK_BANK = 8'h7e;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PMW_SIZE_ONE_LSB = 0;
  localparam int PMW_SIZE_TWO_LSB = 4;
  localparam int PMW_GPCS_SRC_LSB = 6;
  localparam int PMW_BASE_ONE_LSB = 1;
  localparam int PMW_BASE_TWO_LSB = 5;
  localparam int PMW_BANK_LSB = 1;

  // ------------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0] PMW_RESP_OKAY = 2'b00;
  localparam logic [1:0] PMW_RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMW_SZ_OFF = 2'b00,
    PMW_SZ_8K = 2'b01,
    PMW_SZ_16K = 2'b10,
    PMW_SZ_32K = 2'b11
  } pmw_size_t;

  typedef struct packed {
    pmw_size_t size;
    logic [2:0] base;
    logic [5:0] bank;
  } pmw_win_cfg_t;

  typedef struct packed {
    logic hit;
    logic [5:0] xa;
  } pmw_win_res_t;

endpackage : pmw_pkg

// >>> rtl/pmw_window.sv
// Purpose: hit detection and bank address for one expansion window
// Assumes: cpu address is stable for the cycle it is sampled
// Notes: purely combinational; instantiated once per window

`timescale 1ns/10ps

module pmw_window (
  input wire pmw_pkg::pmw_win_cfg_t cfg, // size, base and bank of window
  input wire logic [15:0] cpu_addr,      // 64K cpu address
  output pmw_pkg::pmw_win_res_t res      // hit flag and bits 18..13
);
  import pmw_pkg::*;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  // low base bits below the size are ignored, which gives alignment, except a 32K window with base 4000
  always_comb begin
    res.hit = 1'b0;
    res.xa = {3'b000, cpu_addr[15:13]};
    case (cfg.size)
      PMW_SZ_8K: begin
        res.hit = (cpu_addr[15:13] == cfg.base);
        res.xa = cfg.bank;
      end
      PMW_SZ_16K: begin
        res.hit = (cpu_addr[15:14] == cfg.base[2:1]);
        res.xa = {cfg.bank[5:1], cpu_addr[13]};
      end
      PMW_SZ_32K: begin
        if (cfg.base[2:1] == 2'b01) begin
          // window spans 4000..bfff, folded onto physical 0..7fff
          res.hit = cpu_addr[15] ^ cpu_addr[14];
          res.xa = {cfg.bank[5:2], ~cpu_addr[14], cpu_addr[13]};
        end else begin
          res.hit = (cpu_addr[15] == cfg.base[2]);
          res.xa = {cfg.bank[5:2], cpu_addr[14:13]};
        end
      end
      default: begin
        res.hit = 1'b0;
        res.xa = {3'b000, cpu_addr[15:13]};
      end
    endcase
  end

endmodule : pmw_window

// >>> testbench/pmw_mapper_properties.sv
// Purpose: port-level properties of the window mapper
// Assumes: mapped outputs lag their inputs by one edge
// Notes: port enables must idle high while in reset
`timescale 1ns/10ps
module pmw_mapper_properties (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, low
  input wire logic [15:0] cpu_addr, // cpu address
  input wire logic onchip_sel, // on-chip hit
  input wire logic rom_sel, // rom hit
  input wire logic [5:0] gpio_oe_b, // port enables
  input wire logic [5:0] port_pin_out, // pin value
  input wire logic [5:0] port_pin_oe_b, // pin enable
  input wire logic [18:0] exp_addr, // expanded address
  input wire logic [18:0] gpcs_one_addr, // cs1 address
  input wire logic [18:0] gpcs_two_addr, // cs2 address
  input wire logic rom_respond, // rom answers
  input wire logic [1:0] win_hit // window hits
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // mapping relations
  // ------------------------------------------------------------
  a_low_pass: assert property (
    exp_addr[12:0] == $past(cpu_addr[12:0]))
    else $error("low address bits altered");
  a_one_window: assert property (
    !(win_hit[0] && win_hit[1])) else $error("both windows hit");
  a_onchip_wins: assert property (
    $past(onchip_sel) |-> win_hit == 2'b00)
    else $error("window hit over on-chip memory");
  a_miss_cpu_bits: assert property (
    win_hit == 2'b00 |-> exp_addr[18:13] == {3'b000, $past(cpu_addr[15:13])})
    else $error("bank bits driven without a hit");
  a_rom_bank_zero: assert property (
    rom_respond |-> $past(rom_sel) &&
    (win_hit == 2'b00 || exp_addr[18:16] == 3'b000))
    else $error("rom answered in a nonzero bank");
  a_rom_answers: assert property (
    $past(rom_sel) && (win_hit == 2'b00 || exp_addr[18:16] == 3'b000)
    |-> rom_respond) else $error("rom silent in bank zero");
  a_cs_one_src: assert property (
    gpcs_one_addr == exp_addr || gpcs_one_addr == {3'b000, $past(cpu_addr)})
    else $error("cs1 address from neither source");
  a_cs_two_src: assert property (
    gpcs_two_addr == exp_addr || gpcs_two_addr == {3'b000, $past(cpu_addr)})
    else $error("cs2 address from neither source");
  a_pin_addr_val: assert property (
    ((~port_pin_oe_b & $past(gpio_oe_b)) & (port_pin_out ^ exp_addr[18:13]))
    == 6'h00) else $error("address pin carries wrong bit");
  a_pin_oe_kept: assert property (
    (port_pin_oe_b & ~$past(gpio_oe_b)) == 6'h00)
    else $error("port drive lost on a pin");
  c_win_one: cover property (win_hit == 2'b01);
  c_win_two: cover property (win_hit == 2'b10);
  c_rom_in_win: cover property (rom_respond && win_hit != 2'b00);
endmodule : pmw_mapper_properties

// >>> testbench/pmw_ext_mem.sv
// Purpose: far side of the shared pins, external paged memory
// Assumes: board pull-ups on every shared pin
// Notes: memory only listens, so it never drives these pins
`timescale 1ns/10ps
module pmw_ext_mem (
  input wire logic [5:0] pin_drive, // device pin value
  input wire logic [5:0] pin_oe_b, // device enable, low drives
  output logic [5:0] pin_level // resolved pin level
);
  // released pins go to the pull-up, never keep the last value
  assign pin_level = pin_drive | pin_oe_b;
endmodule : pmw_ext_mem

// >>> testbench/pmw_mapper_test.sv
// Purpose: self-checking bench for the window mapper
// Assumes: single clock, registers reached over axi4-lite
// Notes: expectations come from the bench's own reference model
`timescale 1ns/10ps
module pmw_mapper_test;
  import pmw_pkg::*;
  logic sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic onchip_sel, rom_sel, rom_respond;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, win_hit, r;
  logic [15:0] cpu_addr;
  logic [5:0] gpio_out, gpio_oe_b, gpio_in;
  logic [5:0] port_pin_in, port_pin_out, port_pin_oe_b;
  logic [18:0] exp_addr, gpcs_one_addr, gpcs_two_addr;
  logic [7:0] mr [5];
  logic [7:0] offs [5] = '{PMW_OFF_PIN_ASSIGN, PMW_OFF_WIN_SIZE,
    PMW_OFF_WIN_BASE, PMW_OFF_BANK_ONE, PMW_OFF_BANK_TWO};
  logic [7:0] msk [5] = '{PMW_MASK_PIN_ASSIGN, PMW_MASK_WIN_SIZE,
    PMW_MASK_WIN_BASE, PMW_MASK_BANK, PMW_MASK_BANK};
  logic [7:0] ov [5] = '{8'h3f, 8'h71, 8'h46, 8'h7e, 8'h06};
  logic [15:0] pts [4] = '{16'h6000, 16'h4000, 16'ha000, 16'hc000};
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  pmw_mapper DUT (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_addr, .onchip_sel,
    .rom_sel, .gpio_out, .gpio_oe_b, .gpio_in, .port_pin_in,
    .port_pin_out, .port_pin_oe_b, .exp_addr, .gpcs_one_addr,
    .gpcs_two_addr, .rom_respond, .win_hit);
  pmw_ext_mem u_mem (.pin_drive(port_pin_out), .pin_oe_b(port_pin_oe_b),
    .pin_level(port_pin_in));

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic logic [6:0] win_of(logic [1:0] s, logic [2:0] b,
    logic [5:0] k, logic [15:0] c);
    case (s)
      2'b01: return {c[15:13] == b, k};
      2'b10: return {c[15:14] == b[2:1], k[5:1], c[13]};
      2'b11: begin
        if (b[2]) return {c[15], k[5:2], c[14:13]};
        // a 4000 base spans the 14 boundary, hence the inversion
        if (b[1]) return {c[15] ^ c[14], k[5:2], ~c[14], c[13]};
        return {~c[15], k[5:2], c[14:13]};
      end
      default: return 7'h00;
    endcase
  endfunction : win_of

  function automatic logic [20:0] map_of(logic [15:0] c, logic onc);
    logic [6:0] w1, w2;
    logic h1, h2;
    logic [5:0] xa;
    w1 = win_of(mr[1][1:0], mr[2][3:1], mr[3][6:1], c);
    w2 = win_of(mr[1][5:4], mr[2][7:5], mr[4][6:1], c);
    h1 = w1[6] & ~onc;
    h2 = w2[6] & ~onc & ~h1;
    xa = h1 ? w1[5:0] : (h2 ? w2[5:0] : {3'b000, c[15:13]});
    return {h2, h1, xa, c[12:0]};
  endfunction : map_of

  // ------------------------------------------------------------
  // drivers, entered just after a rising edge
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
    input logic [3:0] st, output logic [1:0] rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : axi_rd

  task automatic set_reg(input int j, input logic [7:0] v);
    axi_wr(offs[j], ($urandom() & 32'hffffff00) | v, 4'hf, r);
    chk(r, PMW_RESP_OKAY);
    mr[j] = v & msk[j];
  endtask : set_reg

  task automatic probe(input logic [15:0] c, input logic onc,
    input logic rom);
    logic [20:0] m;
    logic [5:0] go, ge, po, pe;
    go = 6'($urandom());
    ge = 6'($urandom());
    cpu_addr <= c;
    onchip_sel <= onc;
    rom_sel <= rom;
    gpio_out <= go;
    gpio_oe_b <= ge;
    m = map_of(c, onc);
    po = (mr[0][5:0] & m[18:13]) | (~mr[0][5:0] & go);
    pe = ~mr[0][5:0] & ge;
    // third edge: pin level has looped back through the port input
    repeat (3) @(posedge sys_clk);
    chk(exp_addr, m[18:0]);
    chk(win_hit, m[20:19]);
    chk(rom_respond,
      rom & (m[20:19] == 2'b00 || m[18:16] == 3'b000));
    chk(gpcs_one_addr, mr[1][6] ? m[18:0] : {3'b000, c});
    chk(gpcs_two_addr, mr[1][7] ? m[18:0] : {3'b000, c});
    chk(port_pin_out, po);
    chk(port_pin_oe_b, pe);
    chk(gpio_in, po | pe);
  endtask : probe

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {cpu_addr, onchip_sel, rom_sel, gpio_out} = '0;
    gpio_oe_b = 6'h3f;
    foreach (mr[j]) mr[j] = 8'h00;
    void'($urandom(32'h89cbd5a2));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int j = 0; j < 5; j++) begin
      axi_rd(offs[j], d, r);
      chk(d, 32'h0);
      chk(r, PMW_RESP_OKAY);
      set_reg(j, 8'hff);
      axi_rd(offs[j], d, r);
      chk(d, {24'h0, msk[j]});
      set_reg(j, 8'h00);
    end
    axi_wr(8'h18, 32'hff, 4'hf, r);
    chk(r, PMW_RESP_SLVERR);
    axi_rd(8'h18, d, r);
    chk(r, PMW_RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(PMW_OFF_BANK_ONE, 32'hff, 4'h0, r);
    chk(r, PMW_RESP_OKAY);
    axi_rd(PMW_OFF_BANK_ONE, d, r);
    chk(d, 32'h0);
    $display("register test done");
    foreach (ov[j]) set_reg(j, ov[j]);
    foreach (pts[k]) probe(pts[k], 1'b0, 1'b1);
    probe(16'h6000, 1'b1, 1'b1);
    // status is read only: the write is taken and changes nothing
    axi_wr(PMW_OFF_STATUS, 32'hff, 4'hf, r);
    chk(r, PMW_RESP_OKAY);
    axi_rd(PMW_OFF_STATUS, d, r);
    chk(d, 32'h4);
    $display("overlap test done");
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 5; j++) set_reg(j, 8'($urandom()));
      repeat (8) probe(16'($urandom()), ($urandom() % 4) == 0, 1'($urandom()));
    end
    $display("random mapping test done");
    give_verdict();
  end
endmodule : pmw_mapper_test

bind pmw_mapper pmw_mapper_properties u_props (.sys_clk, .rst_b,
  .cpu_addr, .onchip_sel, .rom_sel, .gpio_oe_b, .port_pin_out,
  .port_pin_oe_b, .exp_addr, .gpcs_one_addr, .gpcs_two_addr,
  .rom_respond, .win_hit);
